// ===== hw/fcs_pkg.sv
/*
  Constants, types and the register map of the flash card slot control block.
  Assumes an AHB-Lite fabric that selects this slave over the 0x18000000 window.
*/
// Functional notes
// [RQ1] Answer AHB reads and writes as slave
// [RQ2] True-IDE 16-bit and I/O task-file modes
// [RQ3] Decode task file, alt status, control, expansion
// [RQ4] Detect bits 9,8 read zero when inserted
// [RQ5] Bit 2 picks software or detect power
// [RQ6] Bit 0 applies card power in software mode
// [RQ7] Bit 1 drives active-low card reset, resets 0
// [RQ8] Reserved bits ignore writes, read zero
// [RQ9] Control register merges status and control
// [RQ10] Detect-sourced power only while card inserted
package fcs_pkg;

  // ==========================================================
  // Address map
  localparam logic [31:0] FCS_TASK_BASE = 32'h1800_0000;
  localparam logic [31:0] FCS_ALT_BASE = 32'h1800_0100;
  localparam logic [31:0] FCS_CTRL_ADDR = 32'h1800_0300;
  localparam logic [31:0] FCS_EXP_ADDR = 32'h1800_0304;
  localparam logic [31:0] FCS_TASK_MASK = 32'hffff_ff00;
  localparam logic [3:0] FCS_TASK_REGS = 4'h8;

  // ==========================================================
  // Control register fields
  localparam int FCS_POWER_BIT = 0;
  localparam int FCS_RESET_BIT = 1;
  localparam int FCS_SRC_BIT = 2;
  localparam int FCS_CD_A_BIT = 8;
  localparam int FCS_CD_B_BIT = 9;
  localparam logic FCS_POWER_RST = 1'b0;
  localparam logic FCS_RESET_RST = 1'b0;
  localparam logic FCS_SRC_RST = 1'b0;
  localparam logic [1:0] FCS_CD_RST = 2'b11;
  localparam logic FCS_MODE_RST = 1'b0;
  localparam logic [31:0] FCS_EXP_RST = 32'h0000_0000;

  // ==========================================================
  // Card access timing
  localparam int FCS_CLK_MHZ = 20;
  localparam int FCS_CYCLE_NS = 600;
  localparam int FCS_CYCLE_CLKS = (FCS_CYCLE_NS * FCS_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // AHB encodings
  localparam logic [1:0] FCS_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] FCS_HTRANS_SEQ = 2'b11;

  typedef enum logic [1:0] {
    FCS_IDLE = 2'b00,
    FCS_STROBE = 2'b01,
    FCS_DONE = 2'b11
  } fcs_state_e;

  typedef struct packed {
    logic [2:0] addr;
    logic alt;
    logic write;
    logic [15:0] wdata;
  } fcs_card_req_s;

  typedef struct packed {
    logic [15:0] data_o;
    logic data_oe;
    logic [2:0] addr;
    logic cs0_low;
    logic cs1_low;
    logic rd_low;
    logic wr_low;
  } fcs_card_pins_s;

endpackage : fcs_pkg

// ===== hw/fcs_card_cycle.sv
/*
  One card bus cycle: strobes a task-file read or write for a fixed time.
  Assumes the card responds within the fixed strobe length.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_card_cycle (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Request
  input wire logic start_i,
  input wire fcs_pkg::fcs_card_req_s req_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Card pins
  input wire logic [15:0] card_data_i,
  output fcs_pkg::fcs_card_pins_s pins_o
);
  import fcs_pkg::*;

  // ==========================================================
  // Cycle sequencer
  fcs_state_e state, next_state;
  logic [7:0] count, next_count;
  fcs_card_pins_s next_pins;
  logic [15:0] next_rdata;

  always_comb begin
    next_state = state;
    next_count = count;
    next_rdata = rdata_o;
    next_pins = pins_o;
    case (state)
      FCS_IDLE: begin
        if (start_i) begin
          next_count = 8'(FCS_CYCLE_CLKS);
          next_state = FCS_STROBE;
          next_pins.addr = req_i.addr;
          next_pins.cs0_low = req_i.alt;
          next_pins.cs1_low = ~req_i.alt;
          next_pins.rd_low = req_i.write;
          next_pins.wr_low = ~req_i.write;
          next_pins.data_o = req_i.wdata;
          next_pins.data_oe = req_i.write;
        end
      end
      FCS_STROBE: begin
        next_count = count - 8'h01;
        if (count == 8'h01) begin
          next_rdata = card_data_i;
          next_pins.rd_low = 1'b1;
          next_pins.wr_low = 1'b1;
          next_state = FCS_DONE;
        end
      end
      FCS_DONE: begin
        // Chip selects drop one cycle after strobes for hold time
        next_pins.cs0_low = 1'b1;
        next_pins.cs1_low = 1'b1;
        next_pins.data_oe = 1'b0;
        next_state = FCS_IDLE;
      end
      default: next_state = FCS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= FCS_IDLE;
      count <= 8'h00;
      rdata_o <= 16'h0000;
      pins_o <= '{data_o: 16'h0000, data_oe: 1'b0, addr: 3'h0,
                  cs0_low: 1'b1, cs1_low: 1'b1, rd_low: 1'b1, wr_low: 1'b1};
    end else begin
      state <= next_state;
      count <= next_count;
      rdata_o <= next_rdata;
      pins_o <= next_pins;
    end
  end

  assign busy_o = (state != FCS_IDLE);
  assign done_o = (state == FCS_DONE);
endmodule : fcs_card_cycle
`default_nettype wire

// ===== hw/fcs_slot.sv
/*
  Flash card slot controller: AHB-Lite slave with task-file window,
  slot control register and expansion word.
  Assumes card detect inputs are synchronous and the card is 16-bit.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_slot (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Mode
  input wire logic io_mode_i,
  // Card slot
  input wire logic card_detect_low_a_i,
  input wire logic card_detect_low_b_i,
  input wire logic [15:0] card_data_i,
  output fcs_pkg::fcs_card_pins_s card_pins_o,
  output logic card_reset_low_o,
  output logic card_power_en_o
);
  import fcs_pkg::*;

  // ==========================================================
  // Address phase capture
  logic act, next_act;
  logic wr, next_wr;
  logic [31:0] addr, next_addr;
  logic err, next_err;
  logic card_start;
  logic card_busy;
  logic card_done;
  logic [15:0] card_rdata;
  fcs_card_req_s card_req;

  logic a_valid;
  logic a_task;
  logic a_alt;
  logic a_ctrl;
  logic a_exp;
  logic a_bad;
  logic stall;

  assign a_valid = hsel_i && hready_i &&
                   (htrans_i == FCS_HTRANS_NONSEQ || htrans_i == FCS_HTRANS_SEQ); // [RQ1]
  assign a_task = (haddr_i & FCS_TASK_MASK) == FCS_TASK_BASE; // [RQ3]
  assign a_alt = (haddr_i & FCS_TASK_MASK) == FCS_ALT_BASE; // [RQ3]
  assign a_ctrl = haddr_i == FCS_CTRL_ADDR; // [RQ3]
  assign a_exp = haddr_i == FCS_EXP_ADDR; // [RQ3]
  // I/O mode forbids alt-register access; task file limited to its registers
  assign a_bad = !(a_task || a_alt || a_ctrl || a_exp) ||
                 (io_mode_i && a_alt) ||
                 ((a_task || a_alt) && haddr_i[7:1] >= 7'(FCS_TASK_REGS)); // [RQ2]

  // ==========================================================
  // Slot registers
  logic power, next_power;
  logic reset_ctl, next_reset_ctl;
  logic src, next_src;
  logic [31:0] exp_word, next_exp_word;
  logic inserted;
  logic reg_wr;

  assign inserted = !card_detect_low_a_i && !card_detect_low_b_i; // [RQ4]
  assign reg_wr = act && wr && !err;

  always_comb begin
    next_power = power;
    next_reset_ctl = reset_ctl;
    next_src = src;
    next_exp_word = exp_word;
    if (reg_wr && addr == FCS_CTRL_ADDR) begin
      // Only bits 2..0 are writable; the rest are dropped
      next_power = hwdata_i[FCS_POWER_BIT]; // [RQ6] [RQ8]
      next_reset_ctl = hwdata_i[FCS_RESET_BIT]; // [RQ7]
      next_src = hwdata_i[FCS_SRC_BIT]; // [RQ5]
    end
    if (reg_wr && addr == FCS_EXP_ADDR) begin
      next_exp_word = hwdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power <= FCS_POWER_RST;
      reset_ctl <= FCS_RESET_RST;
      src <= FCS_SRC_RST;
      exp_word <= FCS_EXP_RST;
    end else begin
      power <= next_power;
      reset_ctl <= next_reset_ctl;
      src <= next_src;
      exp_word <= next_exp_word;
    end
  end

  assign card_power_en_o = src ? inserted : power; // [RQ5] [RQ6] [RQ10]
  assign card_reset_low_o = reset_ctl; // [RQ7]

  // ==========================================================
  // Transfer sequencing
  // Every access is taken as a full word; hsize_i is not decoded
  logic card_phase;
  logic card_done_seen, next_card_done_seen;

  assign card_phase = act && !err &&
                      ((addr & FCS_TASK_MASK) == FCS_TASK_BASE || (addr & FCS_TASK_MASK) == FCS_ALT_BASE);
  assign card_start = card_phase && !card_busy && !card_done_seen;
  assign card_req = '{addr: addr[3:1], alt: (addr & FCS_TASK_MASK) == FCS_ALT_BASE,
                      write: wr, wdata: hwdata_i[15:0]}; // [RQ2]

  // Seen flag stretches the phase one cycle past the card cycle,
  // so read data is registered before ready goes high
  always_comb begin
    next_card_done_seen = card_done_seen;
    if (card_done) begin
      next_card_done_seen = 1'b1;
    end
    // Cleared as each phase ends, so back-to-back card accesses restart
    if (!card_phase || !stall) begin
      next_card_done_seen = 1'b0;
    end
  end

  assign stall = card_phase && !card_done_seen;

  fcs_card_cycle fcs_card_cycle_inst (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(card_start),
    .req_i(card_req),
    .busy_o(card_busy),
    .done_o(card_done),
    .rdata_o(card_rdata),
    .card_data_i(card_data_i),
    .pins_o(card_pins_o)
  );

  // ==========================================================
  // Phase state and read data
  logic err_two, next_err_two;
  logic [31:0] rdata_mux;
  logic [31:0] next_hrdata;

  // Register reads are taken at the address phase from the next-state
  // values, which forwards a write whose data phase ends on that edge
  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (a_ctrl) begin
      rdata_mux[FCS_CD_B_BIT] = card_detect_low_b_i; // [RQ4] [RQ9]
      rdata_mux[FCS_CD_A_BIT] = card_detect_low_a_i; // [RQ4] [RQ9]
      rdata_mux[FCS_SRC_BIT] = next_src; // [RQ9]
      rdata_mux[FCS_RESET_BIT] = next_reset_ctl; // [RQ9]
      rdata_mux[FCS_POWER_BIT] = next_power; // [RQ8] [RQ9]
    end else if (a_exp) begin
      rdata_mux = next_exp_word;
    end
  end

  // Card reads take the card's word as its cycle finishes
  always_comb begin
    next_hrdata = hrdata_o;
    if (card_done && !wr) begin
      next_hrdata = {16'h0000, card_rdata}; // [RQ2]
    end else if (a_valid && !hwrite_i && (a_ctrl || a_exp)) begin
      next_hrdata = rdata_mux; // [RQ1]
    end
  end

  always_comb begin
    next_act = act;
    next_wr = wr;
    next_addr = addr;
    next_err = err;
    next_err_two = 1'b0;
    if (err && !err_two) begin
      next_err_two = 1'b1;
    end else if (!stall) begin
      next_act = a_valid;
      next_wr = hwrite_i;
      next_addr = haddr_i;
      next_err = a_valid && a_bad; // [RQ1]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act <= 1'b0;
      wr <= 1'b0;
      addr <= 32'h0000_0000;
      err <= 1'b0;
      err_two <= 1'b0;
      card_done_seen <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end else begin
      act <= next_act;
      wr <= next_wr;
      addr <= next_addr;
      err <= next_err;
      err_two <= next_err_two;
      card_done_seen <= next_card_done_seen;
      hrdata_o <= next_hrdata;
    end
  end

  // Two-cycle ERROR response as AHB requires; ready is low in the
  // first cycle so the master can drop the transfer behind it
  assign hresp_o = err;
  assign hreadyout_o = !stall && !(err && !err_two);
endmodule : fcs_slot
`default_nettype wire

// ===== sim/fcs_slot_sva.sv
/*
  Checker of the slot controller's bus answers and slot pins.
  Assumes it is bound to fcs_slot and that the detect inputs stay steady around reads.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_slot_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Slot
  input wire logic card_detect_low_a_i,
  input wire logic card_detect_low_b_i,
  input wire fcs_pkg::fcs_card_pins_s card_pins_o,
  input wire logic card_reset_low_o,
  input wire logic card_power_en_o
);
  import fcs_pkg::*;
  // ==========================================================
  // Shadow of the written control bits
  logic take;
  logic ctrl_wr;
  logic [2:0] shadow;
  assign take = hsel_i && hready_i && htrans_i[1];
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_wr <= 1'b0;
      shadow <= 3'h0;
    end else begin
      ctrl_wr <= take && hwrite_i && haddr_i == FCS_CTRL_ADDR;
      if (ctrl_wr && hreadyout_o) begin
        shadow <= hwdata_i[2:0];
      end
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Properties
  pwr_soft_a: assert property (!shadow[2] |-> card_power_en_o == shadow[0])
    else $error("power differs from software bit");
  pwr_detect_a: assert property (shadow[2] |-> card_power_en_o == (!card_detect_low_a_i && !card_detect_low_b_i))
    else $error("power differs from detect state");
  card_reset_a: assert property (card_reset_low_o == shadow[1])
    else $error("card reset pin differs from bit 1");
  ctrl_ready_a: assert property (take && haddr_i == FCS_CTRL_ADDR |=> hreadyout_o && !hresp_o)
    else $error("control access not answered at once");
  refuse_err_a: assert property (take && haddr_i[31:8] == 24'h18_0002 |=> hresp_o && !hreadyout_o ##1 hresp_o && hreadyout_o)
    else $error("unmapped access not refused");
  read_val_a: assert property (take && !hwrite_i && haddr_i == FCS_CTRL_ADDR |=> hrdata_o ==
    {22'h0, $past(card_detect_low_b_i), $past(card_detect_low_a_i), 5'h0, shadow})
    else $error("control read value wrong");
  task_wait_a: assert property (take && haddr_i[31:4] == 28'h180_0000 |=> !hreadyout_o ##[1:20] hreadyout_o)
    else $error("task file access timing wrong");
  strobe_len_a: assert property ($fell(card_pins_o.rd_low) |-> !card_pins_o.rd_low [*8])
    else $error("card read strobe too short");
endmodule : fcs_slot_sva
bind fcs_slot fcs_slot_sva fcs_slot_sva_inst (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .card_detect_low_a_i, .card_detect_low_b_i,
  .card_pins_o, .card_reset_low_o, .card_power_en_o);
`default_nettype wire

// ===== sim/fcs_card_model.sv
/*
  Behavioural flash card: task-file store and detect pins.
  Assumes the slot selects the alternate window with the second chip select.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_card_model (
  // Slot side
  input wire logic clock_i,
  input wire logic inserted_i,
  input wire fcs_pkg::fcs_card_pins_s pins_i,
  output logic [15:0] data_o,
  output logic cd_a_low_o,
  output logic cd_b_low_o
);
  import fcs_pkg::*;
  logic [15:0] mem [16];
  logic [15:0] idle = 16'h5a5a;
  wire logic [3:0] idx = {pins_i.cs0_low, pins_i.addr};
  // Released bus wiggles so a stale value cannot pass
  always @(posedge clock_i) begin
    idle <= ~idle;
    if (!pins_i.wr_low) begin
      mem[idx] <= pins_i.data_o;
    end
  end
  assign data_o = pins_i.rd_low ? idle : mem[idx];
  assign cd_a_low_o = !inserted_i;
  assign cd_b_low_o = !inserted_i;
endmodule : fcs_card_model
`default_nettype wire

// ===== sim/tb_fcs_slot.sv
/*
  Self-checking bench of the slot controller over its bus slave port.
  Assumes the card model answers on the task-file pins.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_fcs_slot;
  import fcs_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic io_mode_i = 1'b0;
  logic inserted = 1'b0;
  logic [31:0] hrdata_o, rd;
  logic hreadyout_o, hresp_o, err, cd_a, cd_b, rst_low, pwr;
  logic [15:0] cdata;
  fcs_card_pins_s pins;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  fcs_slot fcs_slot_inst (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .io_mode_i,
    .card_detect_low_a_i(cd_a), .card_detect_low_b_i(cd_b), .card_data_i(cdata), .card_pins_o(pins),
    .card_reset_low_o(rst_low), .card_power_en_o(pwr));
  fcs_card_model fcs_card_model_inst (.clock_i, .inserted_i(inserted), .pins_i(pins), .data_o(cdata),
    .cd_a_low_o(cd_a), .cd_b_low_o(cd_b));
  // ==========================================================
  // Clock and hang guard
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    hsel_i = 1'b1;
    haddr_i = a;
    htrans_i = FCS_HTRANS_NONSEQ;
    hwrite_i = w;
    err = 1'b0;
    n = 0;
    @(posedge clock_i) #1;
    hsel_i = 1'b0;
    htrans_i = 2'h0;
    hwdata_i = d;
    while (hreadyout_o !== 1'b1 && n < 40) begin
      err |= hresp_o;
      n++;
      @(posedge clock_i) #1;
    end
    err |= hresp_o;
    if (hreadyout_o !== 1'b1) n_errors++;
    // Read data stands with ready in the last data-phase cycle
    rd = hrdata_o;
    @(posedge clock_i) #1;
  endtask : xfer
  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
    xfer(a, 1'b0, 32'h0);
    `CHK(nm, ex, rd)
  endtask : rdchk
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    `CHK("reset_pin", 1'b0, rst_low)
    `CHK("power_off", 1'b0, pwr)
    rdchk("ctrl_empty", FCS_CTRL_ADDR, 32'h300);
    inserted = 1'b1;
    rdchk("ctrl_card", FCS_CTRL_ADDR, 32'h0);
    xfer(FCS_CTRL_ADDR, 1'b1, 32'hffff_ffff);
    rdchk("ctrl_ones", FCS_CTRL_ADDR, 32'h7);
    `CHK("reset_rel", 1'b1, rst_low)
    `CHK("power_det", 1'b1, pwr)
    inserted = 1'b0;
    rdchk("ctrl_gone", FCS_CTRL_ADDR, 32'h307);
    `CHK("power_gone", 1'b0, pwr)
    xfer(FCS_CTRL_ADDR, 1'b1, 32'h1);
    `CHK("power_soft", 1'b1, pwr)
    xfer(FCS_EXP_ADDR, 1'b1, 32'ha5a5_5a5a);
    rdchk("expansion", FCS_EXP_ADDR, 32'ha5a5_5a5a);
    xfer(32'h1800_0200, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err)
    xfer(32'h1800_0004, 1'b1, 32'h0000_beef);
    xfer(32'h1800_010c, 1'b1, 32'h0000_1234);
    rdchk("task_reg", 32'h1800_0004, 32'h0000_beef);
    rdchk("alt_reg", 32'h1800_010c, 32'h0000_1234);
    io_mode_i = 1'b1;
    rdchk("io_task", 32'h1800_0004, 32'h0000_beef);
    xfer(32'h1800_010c, 1'b0, 32'h0);
    `CHK("io_alt", 1'b1, err)
    close_out();
  end
endmodule : tb_fcs_slot
`default_nettype wire
